// file: verilog/pwmlk_pkg.sv
// Package for the PWM write guard, modulation clock and master duty block.
// Assumes a 16-bit register port with one-cycle strobes.
package pwmlk_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 16;
    // Register offsets (word index on the register port)
    localparam logic [3:0]  OFF_KEY         = 4'h0;
    localparam logic [3:0]  OFF_OUTCTL      = 4'h1;
    localparam logic [3:0]  OFF_FLTCTL      = 4'h2;
    localparam logic [3:0]  OFF_MODCLK      = 4'h3;
    localparam logic [3:0]  OFF_MDC         = 4'h4;
    localparam logic [3:0]  OFF_STATUS      = 4'h5;
    // Unlock keys
    localparam logic [15:0] KEY_FIRST       = 16'hABCD;
    localparam logic [15:0] KEY_SECOND      = 16'h4321;
    // Modulation clock control fields
    localparam int          MODCLK_EN_BIT   = 15;
    localparam int          MODCLK_DIV_W    = 10;
    // Reset values
    localparam logic [15:0] RST_OUTCTL      = 16'h0000;
    localparam logic [15:0] RST_FLTCTL      = 16'h0000;
    localparam logic [15:0] RST_MODCLK      = 16'h0000;
    localparam logic [15:0] RST_MDC         = 16'h0000;
    // Status bit positions
    localparam int          ST_UNLOCKED     = 0;
    localparam int          ST_KEY1         = 1;
    localparam int          ST_GUARD        = 2;
    localparam int          ST_MODCLK       = 3;
    typedef enum logic [2:0] {
        LK_IDLE = 3'b001,
        LK_KEY1 = 3'b010,
        LK_OPEN = 3'b100
    } pwmlk_state_t;
endpackage

// file: verilog/pwmlk_top.sv
// PWM write guard, modulation clock generator and master duty register.
// Assumes a register port master that never overlaps strobes, and a
// prescaled PWM clock tick supplied from outside.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pwmlk_top
    import pwmlk_pkg::*;
(
    // Clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_resetn,
    // Configuration and prescaled PWM clock tick
    input  wire logic              i_guard_enable_config_bit,
    input  wire logic              i_pwm_prescale_tick,
    // Register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rdata,
    // Block outputs
    output logic      [DATA_W-1:0] o_output_control_reg,
    output logic      [DATA_W-1:0] o_fault_control_reg,
    output logic      [DATA_W-1:0] o_master_duty_cycle,
    output logic                   o_modulation_clock,
    output logic                   o_unlocked
);
    pwmlk_state_t              lk_reg;
    pwmlk_state_t              lk_next;
    logic [DATA_W-1:0]         outctl_reg;
    logic [DATA_W-1:0]         fltctl_reg;
    logic [DATA_W-1:0]         mdc_reg;
    logic                      modclk_en_reg;
    logic [MODCLK_DIV_W-1:0]   modclk_div_reg;
    logic [MODCLK_DIV_W-1:0]   div_cnt_reg;
    logic [MODCLK_DIV_W-1:0]   div_cnt_next;
    logic                      modclk_out_reg;
    logic [DATA_W-1:0]         rdata_reg;

    wire access     = i_wr | i_rd;
    wire wr_key     = i_wr && (i_addr == OFF_KEY);
    wire wr_outctl  = i_wr && (i_addr == OFF_OUTCTL);
    wire wr_fltctl  = i_wr && (i_addr == OFF_FLTCTL);
    wire wr_guarded = wr_outctl | wr_fltctl;
    wire guard_on   = i_guard_enable_config_bit;
    // Guarded write passes only when unguarded or straight after the keys
    wire grant      = wr_guarded && (!guard_on || lk_reg == LK_OPEN);
    wire div_wrap   = (div_cnt_reg == modclk_div_reg);
    wire [DATA_W-1:0] modclk_view = {modclk_en_reg, 5'h00, modclk_div_reg};
    wire [DATA_W-1:0] status_view = {12'h000, modclk_out_reg, guard_on,
                                     lk_reg == LK_KEY1, lk_reg == LK_OPEN};

    // Unlock sequencer: any access other than the expected key or a repeated first key drops it
    always_comb
    begin
        lk_next = lk_reg;
        if (access)
        begin
            unique case (lk_reg)
                LK_IDLE: lk_next = (wr_key && i_wdata == KEY_FIRST) ? LK_KEY1 : LK_IDLE;
                LK_KEY1: lk_next = (wr_key && i_wdata == KEY_SECOND) ? LK_OPEN
                                 : (wr_key && i_wdata == KEY_FIRST) ? LK_KEY1 : LK_IDLE;
                LK_OPEN: lk_next = LK_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
            lk_reg <= LK_IDLE;
        else
            lk_reg <= lk_next;
    end

    // Guarded registers; refused writes leave them untouched
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            outctl_reg <= RST_OUTCTL;
            fltctl_reg <= RST_FLTCTL;
        end
        else if (grant)
        begin
            if (wr_outctl)
                outctl_reg <= i_wdata;
            if (wr_fltctl)
                fltctl_reg <= i_wdata;
        end
    end

    // Open registers
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            mdc_reg        <= RST_MDC;
            modclk_en_reg  <= RST_MODCLK[MODCLK_EN_BIT];
            modclk_div_reg <= RST_MODCLK[MODCLK_DIV_W-1:0];
        end
        else if (i_wr)
        begin
            if (i_addr == OFF_MDC)
                mdc_reg <= i_wdata;
            if (i_addr == OFF_MODCLK)
            begin
                modclk_en_reg  <= i_wdata[MODCLK_EN_BIT];
                modclk_div_reg <= i_wdata[MODCLK_DIV_W-1:0];
            end
        end
    end

    // Divider counts prescaled ticks; output toggles each divider+1 ticks,
    // so one full period spans 2*(div+1) ticks
    assign div_cnt_next = div_wrap ? '0 : div_cnt_reg + 1'b1;
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            div_cnt_reg    <= '0;
            modclk_out_reg <= 1'b0;
        end
        else if (!modclk_en_reg)
        begin
            div_cnt_reg    <= '0;
            modclk_out_reg <= 1'b0;
        end
        else if (i_pwm_prescale_tick)
        begin
            div_cnt_reg <= div_cnt_next;
            if (div_wrap)
                modclk_out_reg <= ~modclk_out_reg;
        end
    end

    // Read data valid the cycle after the strobe only
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
            rdata_reg <= '0;
        else if (i_rd)
        begin
            unique case (i_addr)
                OFF_OUTCTL: rdata_reg <= outctl_reg;
                OFF_FLTCTL: rdata_reg <= fltctl_reg;
                OFF_MODCLK: rdata_reg <= modclk_view;
                OFF_MDC:    rdata_reg <= mdc_reg;
                OFF_STATUS: rdata_reg <= status_view;
                default:    rdata_reg <= '0;
            endcase
        end
        else
            rdata_reg <= '0;
    end

    assign o_rdata              = rdata_reg;
    assign o_output_control_reg = outctl_reg;
    assign o_fault_control_reg  = fltctl_reg;
    assign o_master_duty_cycle  = mdc_reg;
    assign o_modulation_clock   = modclk_out_reg;
    assign o_unlocked           = (lk_reg == LK_OPEN);

    property p_refused_write;
        @(posedge i_mclk) disable iff (!i_resetn)
        (wr_outctl && guard_on && lk_reg != LK_OPEN) |=> $stable(outctl_reg);
    endproperty
    a_refused_write: assert property (p_refused_write) else $error("guarded write accepted while locked");

    property p_unguarded;
        @(posedge i_mclk) disable iff (!i_resetn)
        (wr_fltctl && !guard_on) |=> (fltctl_reg == $past(i_wdata));
    endproperty
    a_unguarded: assert property (p_unguarded) else $error("unguarded write not taken");

    property p_key_seq;
        @(posedge i_mclk) disable iff (!i_resetn)
        (lk_reg == LK_KEY1 && wr_key && i_wdata == KEY_SECOND) |=> (lk_reg == LK_OPEN);
    endproperty
    a_key_seq: assert property (p_key_seq) else $error("key pair did not unlock");

    property p_granted;
        @(posedge i_mclk) disable iff (!i_resetn)
        (lk_reg == LK_OPEN && wr_outctl) |=> (outctl_reg == $past(i_wdata));
    endproperty
    a_granted: assert property (p_granted) else $error("unlocked write lost");

    property p_one_shot;
        @(posedge i_mclk) disable iff (!i_resetn)
        (lk_reg == LK_OPEN && access) |=> (lk_reg == LK_IDLE);
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("unlock survived an access");

    property p_break;
        @(posedge i_mclk) disable iff (!i_resetn)
        (lk_reg == LK_KEY1 && access && !(wr_key && (i_wdata == KEY_FIRST || i_wdata == KEY_SECOND)))
        |=> (lk_reg == LK_IDLE);
    endproperty
    a_break: assert property (p_break) else $error("broken sequence still granted");

    property p_mod_read;
        @(posedge i_mclk) disable iff (!i_resetn)
        (i_rd && i_addr == OFF_MODCLK) |=> (o_rdata[14:10] == 5'h00 && o_rdata[15] == modclk_en_reg);
    endproperty
    a_mod_read: assert property (p_mod_read) else $error("modulation clock read wrong");

    property p_mod_stop;
        @(posedge i_mclk) disable iff (!i_resetn)
        !modclk_en_reg |=> (!o_modulation_clock && div_cnt_reg == '0);
    endproperty
    a_mod_stop: assert property (p_mod_stop) else $error("modulation clock ran while off");

    property p_mdc;
        @(posedge i_mclk) disable iff (!i_resetn)
        (i_wr && i_addr == OFF_MDC) |=> (o_master_duty_cycle == $past(i_wdata));
    endproperty
    a_mdc: assert property (p_mdc) else $error("master duty readback wrong");
endmodule
`default_nettype wire

// file: tb/pwm_lock_chop_master_duty_tb.sv
// Self-checking bench for the PWM write guard, modulation clock and master duty block.
// Assumes pwmlk_pkg and pwmlk_top are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module pwm_lock_chop_master_duty_tb
    import pwmlk_pkg::*;
;
    logic        i_mclk  = 1'b0;
    logic        i_resetn = 1'b0;
    logic        cfg     = 1'b1;
    logic        tick    = 1'b0;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [3:0]  addr    = 4'h0;
    logic [15:0] wdata   = 16'h0000;
    logic [15:0] rdata;
    logic [15:0] outc;
    logic [15:0] fltc;
    logic [15:0] mdc;
    logic        modclk;
    logic        unl;
    int          error_cnt   = 0;
    int          checks_done = 0;
    int          cyc         = 0;
    int          st          = 0;
    logic [15:0] m [0:15];

    pwmlk_top u_pwmlk_top (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_guard_enable_config_bit(cfg),
        .i_pwm_prescale_tick(tick), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_output_control_reg(outc), .o_fault_control_reg(fltc),
        .o_master_duty_cycle(mdc), .o_modulation_clock(modclk), .o_unlocked(unl)
    );

    always #25 i_mclk = ~i_mclk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Generous ceiling: the longest divider test needs a little over 2048 cycles
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One register access, then the model steps and the read data (reads only), unlock flag and the three register outputs are compared
    task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
        logic [15:0] e;
        e = (a >= 4'h1 && a <= 4'h4) ? m[a] : 16'h0000;
        if (a == OFF_STATUS)
            e = {12'h000, modclk, cfg, st == 1, st == 2};
        @(posedge i_mclk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge i_mclk);
        wr <= 1'b0;
        rd <= 1'b0;
        if (w && a == OFF_KEY)
            st = (st != 2 && d == KEY_FIRST) ? 1 : ((st == 1 && d == KEY_SECOND) ? 2 : 0);
        else
        begin
            if (w && (a == OFF_OUTCTL || a == OFF_FLTCTL) && (!cfg || st == 2))
                m[a] = d;
            if (w && a == OFF_MODCLK)
                m[a] = d & 16'h83FF;
            if (w && a == OFF_MDC)
                m[a] = d;
            st = 0;
        end
        @(negedge i_mclk);
        if (!w)
            cmp(rdata, e);
        cmp({15'h0000, unl}, {15'h0000, st == 2});
        cmp(outc, m[1]);
        cmp(fltc, m[2]);
        cmp(mdc, m[4]);
    endtask

    task automatic unlock();
        acc(1'b1, OFF_KEY, KEY_FIRST);
        acc(1'b1, OFF_KEY, KEY_SECOND);
    endtask

    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, error_cnt);
    endtask

    // Half period of the modulation clock with a tick every cycle
    task automatic mc(input int div);
        int   n;
        logic p;
        n = 0;
        acc(1'b1, OFF_MODCLK, 16'h8000 | 16'(div));
        @(posedge i_mclk) tick <= 1'b1;
        @(negedge i_mclk);
        for (int j = 0; j < 2; j++)
        begin
            p = modclk;
            n = 0;
            while (modclk === p && n < 3000)
            begin
                @(negedge i_mclk);
                n++;
            end
        end
        cmp(16'(n), 16'(div + 1));
        @(posedge i_mclk) tick <= 1'b0;
        acc(1'b1, OFF_MODCLK, 16'(div));
        // Output clears one edge after the enable bit drops
        @(negedge i_mclk);
        cmp({15'h0000, modclk}, 16'h0000);
    endtask

    initial
    begin
        void'($urandom(78));
        for (int k = 0; k < 16; k++)
            m[k] = 16'h0000;
        repeat (16) @(posedge i_mclk);
        i_resetn <= 1'b1;
        for (int a = 0; a < 16; a++)
            acc(1'b0, 4'(a), 16'h0000);
        done("reset");
        acc(1'b1, OFF_OUTCTL, 16'hF000);
        unlock();
        acc(1'b1, OFF_OUTCTL, 16'hF000);
        acc(1'b1, OFF_FLTCTL, 16'($urandom));
        unlock();
        acc(1'b1, OFF_FLTCTL, 16'($urandom));
        done("unlock");
        acc(1'b1, OFF_KEY, KEY_FIRST);
        acc(1'b0, OFF_MDC, 16'h0000);
        acc(1'b1, OFF_KEY, KEY_SECOND);
        acc(1'b1, OFF_OUTCTL, 16'($urandom));
        acc(1'b1, OFF_KEY, KEY_FIRST);
        acc(1'b1, OFF_KEY, 16'h1234);
        acc(1'b1, OFF_KEY, KEY_SECOND);
        acc(1'b1, OFF_FLTCTL, 16'($urandom));
        acc(1'b1, OFF_KEY, KEY_FIRST);
        unlock();
        acc(1'b1, OFF_OUTCTL, 16'($urandom));
        unlock();
        acc(1'b1, OFF_MDC, 16'($urandom));
        acc(1'b1, OFF_OUTCTL, 16'($urandom));
        unlock();
        acc(1'b1, OFF_KEY, KEY_FIRST);
        acc(1'b1, OFF_KEY, KEY_SECOND);
        acc(1'b1, OFF_OUTCTL, 16'($urandom));
        acc(1'b1, OFF_KEY, KEY_FIRST);
        acc(1'b0, OFF_STATUS, 16'h0000);
        unlock();
        acc(1'b0, OFF_STATUS, 16'h0000);
        acc(1'b1, OFF_FLTCTL, 16'($urandom));
        done("sequence");
        @(posedge i_mclk) cfg <= 1'b0;
        acc(1'b1, OFF_OUTCTL, 16'($urandom));
        acc(1'b1, OFF_FLTCTL, 16'($urandom));
        acc(1'b0, OFF_STATUS, 16'h0000);
        @(posedge i_mclk) cfg <= 1'b1;
        done("guard off");
        repeat (4)
        begin
            acc(1'b1, OFF_MODCLK, 16'($urandom));
            acc(1'b0, OFF_MODCLK, 16'h0000);
            acc(1'b1, OFF_MDC, 16'($urandom));
            acc(1'b0, OFF_MDC, 16'h0000);
            acc(1'b1, 4'h9, 16'($urandom));
            acc(1'b0, 4'h9, 16'h0000);
        end
        done("registers");
        // Mid-run reset must bring every writable register back to zero
        @(posedge i_mclk) i_resetn <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_resetn <= 1'b1;
        for (int k = 0; k < 16; k++)
            m[k] = 16'h0000;
        st = 0;
        acc(1'b0, OFF_MDC, 16'h0000);
        acc(1'b0, OFF_MODCLK, 16'h0000);
        done("reset again");
        mc(0);
        mc(3);
        mc(1023);
        mc(int'($urandom % 20));
        done("modulation clock");
        print_verdict();
    end
endmodule
`default_nettype wire
